// ### include/radio_mode_if.sv
`timescale 1ns/1ps
// Link between host and device ends.
interface radio_mode_if;
    logic cfg_port_select_n; // Select line, low while the host configures.
    logic cfg_wr; // One-cycle write strobe for cfg_wdata.
    logic [15:0] cfg_wdata; // Configuration word to the device.
    logic [15:0] cfg_rdata; // Stored configuration word read back.
    logic [1:0] dev_pins_o; // Device drive value of the mode pins.
    logic dev_pins_oe; // High while the device drives the mode pins.
    logic [1:0] host_pins_o; // Host drive value of the mode pins.
    logic host_pins_oe; // High while the host drives the mode pins.
    logic [1:0] mode_pins; // Resolved pin level; undriven pins pull low.

    // The device driver wins; both should never drive together.
    assign mode_pins = dev_pins_oe ? dev_pins_o : (host_pins_oe ? host_pins_o : 2'b00);

    modport device (
        input cfg_port_select_n, cfg_wr, cfg_wdata, mode_pins,
        output cfg_rdata, dev_pins_o, dev_pins_oe
    );
    modport host (
        input cfg_rdata, mode_pins,
        output cfg_port_select_n, cfg_wr, cfg_wdata, host_pins_o, host_pins_oe
    );
endinterface

// ### include/radio_mode_pkg.sv
package radio_mode_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Timing. Figures are in ns; cycle counts derive from the 50 MHz core clock.
    localparam int CLK_PERIOD_NS = 20;
    // Filter calibration time on receive entry.
    localparam int FILTER_CAL_NS = 2000;
    localparam int FILTER_CAL_CYCLES = (FILTER_CAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Filter boost time on a carrier change.
    localparam int FILTER_BOOST_NS = 1000;
    localparam int FILTER_BOOST_CYCLES = (FILTER_BOOST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Least select low time.
    localparam int SEL_LOW_NS = 100;
    localparam int SEL_LOW_CYCLES = (SEL_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration word field positions.
    localparam int CFG_W = 16;
    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_SRC_BIT = 2;
    localparam int CFG_CLKEN_BIT = 3;
    localparam int CFG_DIV_LSB = 4;
    localparam int CFG_EXTCLK_BIT = 7;
    localparam int CFG_XRES_LSB = 8;
    localparam int CFG_FILT_LSB = 12;
    localparam int CFG_CHAN_LSB = 14;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam logic [3:0] XRES_RESET = 4'h0;
    localparam logic [2:0] DIV_POR = 3'h0;
    localparam logic [1:0] FILT_BOOST = 2'h3;

    ////////////////////////////////////////////////////////////////////////////////
    // Host register map on APB, byte addresses.
    localparam logic [7:0] REG_CFG = 8'h00;
    localparam logic [7:0] REG_PINS = 8'h04;
    localparam logic [7:0] REG_CMD = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;

    // Operating mode codes.
    typedef enum logic [1:0] {
        MODE_SLEEP = 2'b00,
        MODE_RX = 2'b01,
        MODE_TX = 2'b10,
        MODE_STANDBY = 2'b11
    } op_mode_t;

endpackage

// ### rtl/clk_out_divider.sv
`timescale 1ns/1ps
// Divides the reference by 2, 4, 8, 16 or 32 and holds low while stopped.
module clk_out_divider
    import radio_mode_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_run,
    input wire logic [2:0] i_ratio_sel,
    output logic o_clk
);

    logic [3:0] cnt; // Cycles spent in the current half period.

    // Half period minus one: code 000 gives /32, 001 /16, 010 /8, 011 /4, the rest /2.
    function automatic logic [3:0] half_last(input logic [2:0] sel);
        case (sel)
            3'h0: half_last = 4'hf;
            3'h1: half_last = 4'h7;
            3'h2: half_last = 4'h3;
            3'h3: half_last = 4'h1;
            default: half_last = 4'h0;
        endcase
    endfunction

    wire last = (cnt >= half_last(i_ratio_sel));

    ////////////////////////////////////////////////////////////////////////////////
    // Toggle at each half period; a stopped divider parks low and restarts clean.
    always_ff @(posedge i_clk) begin
        if (i_rst || !i_run) begin
            cnt <= 4'h0;
            o_clk <= 1'b0;
        end else if (last) begin
            cnt <= 4'h0;
            o_clk <= ~o_clk;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end

endmodule

// ### rtl/radio_mode_device.sv
`timescale 1ns/1ps
// How it works
// - Register field or pins pick mode per source bit.
// - Mode changes apply only on select rising edge.
// - Host pulses select low then high to commit.
// - 00 sleep, 01 receive, 10 transmit, 11 standby.
// - Pins are outputs when source bit low.
// - Pin-driven mode ignores field; field stays readable.
// - Receive entry runs filter calibration before ready.
// - Carrier change with filter field 11 boosts.
// - Host sets external clock bit for external clock.
// - Parallel-resistor field resets to 0000.
// - Oscillator may run fundamental until resistor programmed.
// - Host waits oscillator settling before timed work.
// - Enabled clock output is reference divided down.
// - Divider codes 000..011 and others map frequencies.
// - Clock output inactive in sleep mode after first commit.
// - Power-on reset clears all configuration to zero.
// - After reset clock output runs at 1.22 MHz.
// - First commit applies registers, may stop clock.
// - Host enables clock output in first sequence.
// - Host programs all registers right after power-up.
module radio_mode_device
    import radio_mode_pkg::*;
#(
    parameter int CAL_CYCLES = FILTER_CAL_CYCLES,
    parameter int BOOST_CYCLES = FILTER_BOOST_CYCLES,
    parameter int CNT_W = 12
)
(
    input wire logic I_CORE_CLK,
    input wire logic I_RST,
    radio_mode_if.device link,
    output logic [1:0] O_MODE,
    output logic O_OSC_EN,
    output logic O_SYNTH_EN,
    output logic O_RX_EN,
    output logic O_TX_EN,
    output logic O_RX_READY,
    output logic O_FILTER_BOOST,
    output logic O_EXT_CLOCK_SEL,
    output logic [3:0] O_XTAL_PARALLEL_RES,
    output logic O_CLK_OUT
);

    ////////////////////////////////////////////////////////////////////////////////
    // Parameter checks at elaboration.
    if (CAL_CYCLES < 1 || CAL_CYCLES >= (1 << CNT_W)) begin : g_bad_cal
        $error("CAL_CYCLES does not fit the settle counter.");
    end
    if (BOOST_CYCLES < 1 || BOOST_CYCLES >= (1 << CNT_W)) begin : g_bad_boost
        $error("BOOST_CYCLES does not fit the settle counter.");
    end

    // Receive path states.
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_CAL = 2'b01,
        RX_BOOST = 2'b10,
        RX_DONE = 2'b11
    } rx_state_t;

    ////////////////////////////////////////////////////////////////////////////////
    // Storage.
    logic [15:0] pend; // Written configuration, not yet applied.
    logic sel_q; // Select line one cycle earlier.
    op_mode_t mode; // Applied operating mode.
    logic clk_en; // Applied clock output enable.
    logic [2:0] div_sel; // Applied divider select.
    logic [1:0] chan; // Applied carrier select.
    logic por_clk; // Clock output forced on until the first commit.
    rx_state_t rx_state; // Receive filter sequencing.
    logic [CNT_W-1:0] settle; // Cycles left in calibration or boost.

    ////////////////////////////////////////////////////////////////////////////////
    // Decode of pending word and commit edge.
    wire commit = !sel_q && link.cfg_port_select_n;
    wire wr_ok = link.cfg_wr && !link.cfg_port_select_n;
    wire pend_src = pend[CFG_SRC_BIT];
    wire [1:0] pend_field = pend[CFG_MODE_LSB +: 2];
    wire [1:0] pend_chan = pend[CFG_CHAN_LSB +: 2];
    wire [1:0] pend_filt = pend[CFG_FILT_LSB +: 2];
    // With the pins in charge the field is kept but not used.
    wire [1:0] next_mode_code = pend_src ? link.mode_pins : pend_field;
    wire next_is_rx = (next_mode_code == MODE_RX);
    wire rx_entry = commit && next_is_rx && (mode != MODE_RX);
    wire carrier_change = commit && next_is_rx && (mode == MODE_RX) && (pend_chan != chan);
    wire boost_pick = (pend_filt == FILT_BOOST);
    wire settle_done = (settle == {CNT_W{1'b0}});
    // The power-on clock ignores sleep; the enabled clock does not.
    wire clk_run = por_clk || (clk_en && (mode != MODE_SLEEP));
    wire [2:0] clk_div = por_clk ? DIV_POR : div_sel;

    ////////////////////////////////////////////////////////////////////////////////
    // Link side: read-back and the pin drivers.
    // The field reads back even while the pins set the mode.
    assign link.cfg_rdata = pend;
    // Pin direction follows the stored source bit so that a commit reading the
    // pins never sees the device's own drive.
    assign link.dev_pins_oe = !pend_src;
    assign link.dev_pins_o = mode;

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration write and edge detector; writes land only while selected.
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            pend <= CFG_RESET;
            sel_q <= 1'b1;
        end else begin
            sel_q <= link.cfg_port_select_n;
            if (wr_ok) begin
                pend <= link.cfg_wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Applied settings change on the commit edge only.
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            mode <= MODE_SLEEP;
            clk_en <= 1'b0;
            div_sel <= 3'h0;
            chan <= 2'h0;
            O_EXT_CLOCK_SEL <= 1'b0;
            O_XTAL_PARALLEL_RES <= XRES_RESET;
            por_clk <= 1'b1;
        end else if (commit) begin
            mode <= op_mode_t'(next_mode_code);
            clk_en <= pend[CFG_CLKEN_BIT];
            div_sel <= pend[CFG_DIV_LSB +: 3];
            chan <= pend_chan;
            // The oscillator may run at its fundamental until this lands.
            O_EXT_CLOCK_SEL <= pend[CFG_EXTCLK_BIT];
            O_XTAL_PARALLEL_RES <= pend[CFG_XRES_LSB +: 4];
            por_clk <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Block enables decoded from the applied mode, one cycle behind it.
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            O_MODE <= MODE_SLEEP;
            O_OSC_EN <= 1'b0;
            O_SYNTH_EN <= 1'b0;
            O_RX_EN <= 1'b0;
            O_TX_EN <= 1'b0;
        end else begin
            O_MODE <= mode;
            O_OSC_EN <= (mode != MODE_SLEEP);
            O_SYNTH_EN <= (mode == MODE_RX) || (mode == MODE_TX);
            O_RX_EN <= (mode == MODE_RX);
            O_TX_EN <= (mode == MODE_TX);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Receive filter sequencing: entry calibrates, a carrier change boosts
    // or recalibrates, leaving receive abandons the run.
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            rx_state <= RX_IDLE;
            settle <= {CNT_W{1'b0}};
        end else if (commit && !next_is_rx) begin
            rx_state <= RX_IDLE;
            settle <= {CNT_W{1'b0}};
        end else if (rx_entry || (carrier_change && !boost_pick)) begin
            rx_state <= RX_CAL;
            settle <= CNT_W'(CAL_CYCLES - 1);
        end else if (carrier_change) begin
            rx_state <= RX_BOOST;
            settle <= CNT_W'(BOOST_CYCLES - 1);
        end else begin
            case (rx_state)
                RX_CAL, RX_BOOST: begin
                    if (settle_done) begin
                        rx_state <= RX_DONE;
                    end else begin
                        settle <= settle - CNT_W'(1);
                    end
                end
                RX_IDLE, RX_DONE: begin
                    rx_state <= rx_state;
                end
                default: begin
                    rx_state <= RX_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Status flags, registered from the sequencer state.
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            O_RX_READY <= 1'b0;
            O_FILTER_BOOST <= 1'b0;
        end else begin
            O_RX_READY <= (rx_state == RX_DONE);
            O_FILTER_BOOST <= (rx_state == RX_BOOST);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Clock output. The divider runs on the core clock standing in for the
    // 39 MHz reference, so pin frequencies scale with that clock.
    clk_out_divider u_div (
        .i_clk(I_CORE_CLK),
        .i_rst(I_RST),
        .i_run(clk_run),
        .i_ratio_sel(clk_div),
        .o_clk(O_CLK_OUT)
    );

endmodule

// ### rtl/radio_mode_host.sv
`timescale 1ns/1ps
// Host end: APB registers, commit sequencing and the mode pin drive.
module radio_mode_host
    import radio_mode_pkg::*;
#(
    parameter int LOW_CYCLES = SEL_LOW_CYCLES
)
(
    input wire logic I_CORE_CLK,
    input wire logic I_RST,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    radio_mode_if.host link
);

    if (LOW_CYCLES < 1 || LOW_CYCLES > 255) begin : g_bad_low
        $error("LOW_CYCLES must be 1 to 255.");
    end

    // Commit sequence states.
    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_WRITE = 2'b01,
        H_HOLD = 2'b10,
        H_RISE = 2'b11
    } host_state_t;

    host_state_t state; // Commit sequencer.
    logic [7:0] low_cnt; // Cycles left with select low.
    logic [15:0] cfg_word; // Word sent on the next commit.
    logic [1:0] pin_val; // Mode driven on the pins in pin mode.
    logic src_sent; // Source bit last sent; governs pin drive.

    ////////////////////////////////////////////////////////////////////////////////
    // APB decode. The setup cycle arms a one-cycle pready for the access phase.
    wire setup = I_PSEL && !I_PENABLE;
    wire hit_cfg = (I_PADDR == REG_CFG);
    wire hit_pins = (I_PADDR == REG_PINS);
    wire hit_cmd = (I_PADDR == REG_CMD);
    wire hit_stat = (I_PADDR == REG_STATUS);
    wire mapped = hit_cfg || hit_pins || hit_cmd || hit_stat;
    wire wr_take = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && !O_PSLVERR;
    wire busy = (state != H_IDLE);
    // A commit asked for while busy is dropped; software polls busy first.
    wire go = wr_take && hit_cmd && I_PWDATA[0] && !busy;
    wire [31:0] rd_mux = hit_cfg ? {16'h0000, cfg_word} :
                         hit_pins ? {30'h0, pin_val} :
                         hit_stat ? {link.cfg_rdata, 12'h000, link.mode_pins, 1'b0, busy} :
                         32'h00000000;

    ////////////////////////////////////////////////////////////////////////////////
    // APB answer flops.
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            O_PREADY <= 1'b0;
            O_PSLVERR <= 1'b0;
            O_PRDATA <= 32'h00000000;
        end else begin
            O_PREADY <= setup;
            O_PSLVERR <= setup && !mapped;
            if (setup) begin
                O_PRDATA <= I_PWRITE ? 32'h00000000 : rd_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Host registers. Held across a commit so the sent word stays consistent.
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            cfg_word <= CFG_RESET;
            pin_val <= 2'h0;
        end else if (wr_take && !busy) begin
            if (hit_cfg) begin
                cfg_word <= I_PWDATA[15:0];
            end
            if (hit_pins) begin
                pin_val <= I_PWDATA[1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Commit sequencer: select low with one write, hold, then release high.
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            state <= H_IDLE;
            low_cnt <= 8'h00;
            src_sent <= 1'b0;
        end else begin
            case (state)
                H_IDLE: begin
                    if (go) begin
                        state <= H_WRITE;
                    end
                end
                H_WRITE: begin
                    src_sent <= cfg_word[CFG_SRC_BIT];
                    low_cnt <= 8'(LOW_CYCLES - 1);
                    state <= H_HOLD;
                end
                H_HOLD: begin
                    if (low_cnt == 8'h00) begin
                        state <= H_RISE;
                    end else begin
                        low_cnt <= low_cnt - 8'h01;
                    end
                end
                default: begin
                    state <= H_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Link drive.
    assign link.cfg_port_select_n = !((state == H_WRITE) || (state == H_HOLD));
    assign link.cfg_wr = (state == H_WRITE);
    assign link.cfg_wdata = cfg_word;
    assign link.host_pins_oe = src_sent;
    assign link.host_pins_o = pin_val;

endmodule

// ### tb/radio_mode_and_clock_out_control_tb.sv
`timescale 1ns/1ps
// Drives the host end over APB and judges what the device end applies.
module radio_mode_and_clock_out_control_tb;
    import radio_mode_pkg::*;
    // Short settle times keep the run brief.
    localparam int CAL = 3;
    localparam int BST = 2;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err;
    logic [1:0] mode, pins, m;
    logic osc_en, synth_en, rx_en, tx_en, rx_ready, boost, ext_sel, clk_out;
    logic boost_seen = 1'b0; // Latches any cycle of boost.
    logic [3:0] xres;
    logic [15:0] cfg;
    logic [31:0] lfsr = 32'd73762; // Fixed seed makes the run repeatable.
    int err_count = 0;
    int n_tests = 0;
    int cycles = 0;
    int n;
    radio_mode_if link();

    radio_mode_host #(.LOW_CYCLES(1)) radio_mode_host_i (.I_CORE_CLK(clk), .I_RST(rst),
        .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
        .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .link(link));
    radio_mode_device #(.CAL_CYCLES(CAL), .BOOST_CYCLES(BST)) radio_mode_device_i (
        .I_CORE_CLK(clk), .I_RST(rst), .link(link), .O_MODE(mode), .O_OSC_EN(osc_en),
        .O_SYNTH_EN(synth_en), .O_RX_EN(rx_en), .O_TX_EN(tx_en), .O_RX_READY(rx_ready),
        .O_FILTER_BOOST(boost), .O_EXT_CLOCK_SEL(ext_sel), .O_XTAL_PARALLEL_RES(xres),
        .O_CLK_OUT(clk_out));
    radio_mode_asserts #(.CAL_CYCLES(CAL), .BOOST_CYCLES(BST)) radio_mode_asserts_i (
        .I_CORE_CLK(clk), .I_RST(rst), .cfg_port_select_n(link.cfg_port_select_n),
        .cfg_rdata(link.cfg_rdata), .dev_pins_oe(link.dev_pins_oe),
        .mode_pins(link.mode_pins), .O_MODE(mode), .O_OSC_EN(osc_en), .O_SYNTH_EN(synth_en),
        .O_RX_EN(rx_en), .O_TX_EN(tx_en), .O_RX_READY(rx_ready), .O_FILTER_BOOST(boost),
        .O_CLK_OUT(clk_out));

    ////////////////////////////////////////
    // Clock, hang guard and boost watcher.
    initial begin
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        boost_seen <= boost_seen | (boost === 1'b1);
        if (cycles == 10000) begin
            err_count++;
            report_and_stop();
        end
    end

    ////////////////////////////////////////
    // Expectation functions.
    function automatic logic [31:0] lfsr_f(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [1:0] exp_mode_f(input logic [15:0] c, input logic [1:0] p);
        return c[CFG_SRC_BIT] ? p : c[1:0];
    endfunction
    function automatic logic [3:0] exp_en_f(input logic [1:0] x);
        return {x != MODE_SLEEP, x == MODE_RX || x == MODE_TX, x == MODE_RX, x == MODE_TX};
    endfunction
    function automatic logic [31:0] exp_half_f(input logic [2:0] s);
        return (s > 3'h3) ? 32'h1 : 32'h10 >> s;
    endfunction

    ////////////////////////////////////////
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
        end
    endtask
    // One APB transfer; the request stands until pready is seen high.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Pins first, so the host drives them before the commit.
    task automatic commit(input logic [15:0] c, input logic [1:0] p);
        apb(1'b1, REG_PINS, {30'h0, p});
        apb(1'b1, REG_CFG, {16'h0, c});
        apb(1'b1, REG_CMD, 32'h1);
        do apb(1'b0, REG_STATUS, 32'h0); while (rd[0] !== 1'b0);
        tick(4);
    endtask
    // Counts cycles between two clock output edges; 100 means stopped.
    task automatic half_period(output int k);
        logic v;
        int w;
        w = 0;
        v = clk_out;
        while (clk_out === v && w < 100) begin
            tick(1);
            w++;
        end
        v = clk_out;
        k = 0;
        while (clk_out === v && k < 100) begin
            tick(1);
            k++;
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        tick(2);
        check_val(32'({mode, xres, ext_sel, osc_en, rx_ready}), 32'h0);
        apb(1'b0, REG_STATUS, 32'h0);
        check_val(32'(rd[31:16]), 32'(CFG_RESET));
        half_period(n);
        check_val(n, 32'h10);
        apb(1'b0, 8'h10, 32'h0);
        check_val(32'(err), 32'h1);
        // The first eight commits walk every mode field code with the source bit low and high.
        for (int i = 0; i < 24; i++) begin
            lfsr = lfsr_f(lfsr);
            cfg = lfsr[15:0];
            if (i < 8) begin
                cfg[2:0] = i[2:0];
            end
            pins = lfsr[17:16];
            commit(cfg, pins);
            m = exp_mode_f(cfg, pins);
            check_val(32'(mode), 32'(m));
            check_val(32'({osc_en, synth_en, rx_en, tx_en}), 32'(exp_en_f(m)));
            check_val(32'({ext_sel, xres}), 32'({cfg[7], cfg[11:8]}));
            apb(1'b0, REG_STATUS, 32'h0);
            check_val(32'(rd[31:16]), 32'(cfg));
            if (cfg[CFG_SRC_BIT]) begin
                check_val(32'(rd[3:2]), 32'(pins));
            end
            apb(1'b1, REG_PINS, {30'h0, ~pins});
            apb(1'b1, REG_CFG, {16'h0, ~cfg});
            tick(3);
            check_val(32'(mode), 32'(m));
            if (m == MODE_RX) begin
                tick(CAL + BST + 4);
                check_val(32'(rx_ready), 32'h1);
            end
        end
        for (int s = 0; s < 8; s++) begin
            commit({8'h0, 1'b0, s[2:0], 1'b1, 1'b0, MODE_STANDBY}, 2'b00);
            half_period(n);
            check_val(n, exp_half_f(s[2:0]));
        end
        commit({12'h0, 1'b1, 1'b0, MODE_SLEEP}, 2'b00);
        half_period(n);
        check_val(n, 32'd100);
        commit({12'h0, 1'b0, 1'b0, MODE_STANDBY}, 2'b00);
        half_period(n);
        check_val(n, 32'd100);
        commit(16'h3001, 2'b00);
        tick(CAL + 4);
        boost_seen = 1'b0;
        commit(16'h7001, 2'b00);
        check_val(32'({boost_seen, rx_ready}), 32'h3);
        report_and_stop();
    end
endmodule

// ### tb/radio_mode_asserts.sv
`timescale 1ns/1ps
// Checks the link and the device outputs.
module radio_mode_asserts
    import radio_mode_pkg::*;
#(
    parameter int CAL_CYCLES = FILTER_CAL_CYCLES,
    parameter int BOOST_CYCLES = FILTER_BOOST_CYCLES
)
(
    input wire logic I_CORE_CLK,
    input wire logic I_RST,
    input wire logic cfg_port_select_n,
    input wire logic [15:0] cfg_rdata,
    input wire logic dev_pins_oe,
    input wire logic [1:0] mode_pins,
    input wire logic [1:0] O_MODE,
    input wire logic O_OSC_EN,
    input wire logic O_SYNTH_EN,
    input wire logic O_RX_EN,
    input wire logic O_TX_EN,
    input wire logic O_RX_READY,
    input wire logic O_FILTER_BOOST,
    input wire logic O_CLK_OUT
);
    localparam int CAL_LO = CAL_CYCLES - 1; // Cycles after the enable that ready stays low.
    localparam int BST_LO = BOOST_CYCLES - 1; // Earliest end of a boost.
    localparam int BST_HI = BOOST_CYCLES + 2; // Latest end of a boost.
    logic sel_q; // Select line one cycle ago.
    logic committed; // Set by the first commit after reset.
    logic clk_en_q; // Clock output enable taken at the last commit.
    logic [1:0] exp_mode; // Mode the last commit should apply.
    wire rise = cfg_port_select_n && !sel_q; // Commit edge seen.
    wire stop_cond = committed && (O_MODE == MODE_SLEEP || !clk_en_q); // Clock must stand.

    ////////////////////////////////////////
    // The expected mode is taken at the commit edge, so later pin or field
    // changes cannot leak into it.
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            sel_q <= 1'b1;
            committed <= 1'b0;
            clk_en_q <= 1'b0;
            exp_mode <= MODE_SLEEP;
        end else begin
            sel_q <= cfg_port_select_n;
            if (rise) begin
                committed <= 1'b1;
                clk_en_q <= cfg_rdata[CFG_CLKEN_BIT];
                exp_mode <= cfg_rdata[CFG_SRC_BIT] ? mode_pins : cfg_rdata[1:0];
            end
        end
    end

    ////////////////////////////////////////
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RST);

    sequence s_commit;
        rise;
    endsequence
    sequence s_por_high;
        (O_CLK_OUT || committed) [*8] ##1 (O_CLK_OUT || committed) [*8];
    endsequence

    property p_pins_dir;
        $stable(cfg_rdata[CFG_SRC_BIT]) |-> dev_pins_oe == !cfg_rdata[CFG_SRC_BIT];
    endproperty
    a_pins_dir: assert property (p_pins_dir) else $error("pin direction wrong");
    property p_mode_hold;
        $changed(O_MODE) |-> $past(rise, 2);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode moved");
    property p_mode_src;
        s_commit |-> ##2 O_MODE == exp_mode;
    endproperty
    a_mode_src: assert property (p_mode_src) else $error("mode source");
    property p_enables;
        O_OSC_EN == (O_MODE != MODE_SLEEP) && O_RX_EN == (O_MODE == MODE_RX)
            && O_TX_EN == (O_MODE == MODE_TX)
            && O_SYNTH_EN == (O_MODE == MODE_RX || O_MODE == MODE_TX);
    endproperty
    a_enables: assert property (p_enables) else $error("block enables");
    property p_cal;
        $rose(O_RX_EN) |-> (!O_RX_READY throughout (##CAL_LO 1)) ##[1:2] O_RX_READY;
    endproperty
    a_cal: assert property (p_cal) else $error("calibration time");
    property p_boost;
        $rose(O_FILTER_BOOST) |-> ##[BST_LO:BST_HI] (O_RX_READY && !O_FILTER_BOOST);
    endproperty
    a_boost: assert property (p_boost) else $error("boost time");
    property p_por_clk;
        $rose(O_CLK_OUT) && !committed |-> s_por_high ##1 (!O_CLK_OUT || committed);
    endproperty
    a_por_clk: assert property (p_por_clk) else $error("reset clock rate");
    property p_clk_stop;
        stop_cond [*3] |-> !O_CLK_OUT;
    endproperty
    a_clk_stop: assert property (p_clk_stop) else $error("clock not stopped");
endmodule
